// ==== rtl/lfld_pkg.sv ====
// lfld_pkg: constants, register map and carrier types of the lin channel
// assumes a 10 mhz system clock and one shared synchronous reset
package lfld_pkg;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ       = 10_000_000;
  localparam int BAUD_HZ      = 19_200;
  localparam int BIT_CYC      = CLK_HZ / BAUD_HZ;  // whole cycles per bit, rounded down
  localparam int BRK_LOW_BASE = 13;                // dominant bits at field value 0
  localparam int BRK_DLM_BASE = 1;                 // recessive bits at field value 0
  localparam int SPACE_BITS   = 1;                 // interbyte space in bit times
  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int         AW        = 8;
  localparam int         BUF_DEPTH = 16;
  localparam logic [7:0] OFS_MODE  = 8'h00;
  localparam logic [7:0] OFS_BRK   = 8'h04;
  localparam logic [7:0] OFS_RFC   = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0c;
  localparam logic [7:0] OFS_LDIC  = 8'h10;
  localparam logic [1:0] OFS_DATA_HI = 2'h1;       // 0x40..0x7c, one byte per word
  localparam int RFC_DIR_BIT   = 4;
  localparam int RFC_GO_BIT    = 5;
  localparam int RFC_ABORT_BIT = 6;
  localparam int LDIC_REQ_BIT  = 3;
  localparam logic [5:0] RST_BRK  = 6'h00;
  localparam logic [3:0] RST_CNT  = 4'h0;
  localparam logic [2:0] RST_PRIO = 3'h0;
  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] dlm;
    logic [3:0] low;
  } lfld_brk_t;
  typedef struct packed {
    logic low_det;
    logic err;
    logic done;
  } lfld_stat_t;
  typedef struct packed {
    logic       done;
    logic       err;
    logic [7:0] data;
  } lfld_byte_res_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_BRK_LOW, ST_BRK_DLM, ST_TX_BYTE, ST_TX_SPACE, ST_RX_BYTE
  } lfld_state_t;
endpackage

// ==== rtl/lfld_serdes.sv ====
// lfld_serdes: one 8n1 byte on the lin wire, sent or received
// assumes rx_pin_i is already synchronised and en_i is held for the byte
`timescale 1ns/10ps
module lfld_serdes #(
  parameter int BIT_CYC = lfld_pkg::BIT_CYC
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             en_i,
  input  wire logic             tx_mode_i,
  input  wire logic [7:0]       tx_byte_i,
  // wire
  input  wire logic             rx_pin_i,
  output logic                  tx_o,
  // result
  output lfld_pkg::lfld_byte_res_t res_o
);
  import lfld_pkg::*;
  localparam int            CW       = $clog2(BIT_CYC);
  localparam logic [CW-1:0] CYC_LAST = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] CYC_MID  = CW'(BIT_CYC / 2);

  logic          run,  next_run;
  logic [CW-1:0] cyc,  next_cyc;
  logic [3:0]    bitn, next_bitn;
  logic [9:0]    txsh, next_txsh;
  logic [7:0]    rxsh, next_rxsh;
  logic          err,  next_err;
  logic          last;

  // ------------------------------------------------------------------
  // bit engine: start, 8 data lsb first, stop; mid-bit sampling
  // ------------------------------------------------------------------
  always_comb begin
    next_run  = run;
    next_cyc  = cyc;
    next_bitn = bitn;
    next_txsh = txsh;
    next_rxsh = rxsh;
    next_err  = err;
    last      = run && en_i && (cyc == CYC_LAST) && (bitn == 4'h9);
    if (!run) begin
      // receive waits for the start bit; transmit drives its start bit in this
      // very cycle and counts it as cycle zero, so no idle gap stretches the line
      if (en_i && (tx_mode_i || !rx_pin_i)) begin
        next_run  = 1'b1;
        next_cyc  = tx_mode_i ? CW'(1) : '0;
        next_bitn = 4'h0;
        next_err  = 1'b0;
        next_txsh = {1'b1, tx_byte_i, 1'b0};
      end
    end else if (!en_i) begin
      next_run = 1'b0;  // owner gave up the byte
    end else begin
      next_cyc = cyc + CW'(1);
      if (cyc == CYC_MID) begin
        if (tx_mode_i) begin
          // readback catches a bit overwritten on the wire
          if (rx_pin_i != txsh[0]) next_err = 1'b1;
        end else if (bitn == 4'h0) begin
          if (rx_pin_i) next_err = 1'b1;
        end else if (bitn == 4'h9) begin
          if (!rx_pin_i) next_err = 1'b1;
        end else begin
          next_rxsh = {rx_pin_i, rxsh[7:1]};
        end
      end
      if (cyc == CYC_LAST) begin
        next_cyc  = '0;
        next_txsh = {1'b1, txsh[9:1]};
        if (bitn == 4'h9) next_run = 1'b0;
        else next_bitn = bitn + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      run  <= 1'b0;
      cyc  <= '0;
      bitn <= 4'h0;
      txsh <= 10'h3ff;
      rxsh <= 8'h00;
      err  <= 1'b0;
    end else begin
      run  <= next_run;
      cyc  <= next_cyc;
      bitn <= next_bitn;
      txsh <= next_txsh;
      rxsh <= next_rxsh;
      err  <= next_err;
    end
  end

  assign tx_o       = run ? (txsh[0] || !tx_mode_i) : !(en_i && tx_mode_i);
  assign res_o.done = last;
  assign res_o.err  = err;
  assign res_o.data = rxsh;
endmodule // lfld_serdes

// ==== rtl/lfld_channel.sv ====
// lfld_channel: lin channel with break generator, response engine and low detect
// assumes an avalon-mm master on sys_clk_i and an external lin transceiver
// Behaviour
// R01 - status flags clear only by writing zero
// R02 - set low-detect flag blocks new low-detect requests
// R03 - break low length from four-bit field
// R04 - break delimiter length from two-bit field
// R05 - transmit bytes plus spaces; error aborts
// R06 - receive bytes on start bit; error aborts
// R07 - low detect on falling edge or enable-while-low
// R08 - merged channel request blocked while flag set
// R09 - software disables low request before wait mode
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module lfld_channel #(
  parameter int BIT_CYC = lfld_pkg::BIT_CYC
) (
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  // avalon-mm slave
  input  wire logic [lfld_pkg::AW-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // lin transceiver
  input  wire logic                   bus_input_pin_i,
  output logic                        bus_tx_o,
  // interrupt requests
  output logic                        chan_int_o,
  output logic                        low_int_o
);
  import lfld_pkg::*;
  localparam int            CW       = $clog2(BIT_CYC);
  localparam logic [CW-1:0] CYC_LAST = CW'(BIT_CYC - 1);

  // ------------------------------------------------------------------
  // pin synchroniser; sync_a feeds only pin_s
  // ------------------------------------------------------------------
  logic sync_a, pin_s, pin_d;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync_a <= 1'b1;
      pin_s  <= 1'b1;
      pin_d  <= 1'b1;
    end else begin
      sync_a <= bus_input_pin_i;
      pin_s  <= sync_a;
      pin_d  <= pin_s;
    end
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  lfld_state_t    state, next_state;
  logic [CW-1:0]  cyc,   next_cyc;
  logic [4:0]     bits,  next_bits;
  logic [3:0]     idx,   next_idx;
  lfld_brk_t      brk,   next_brk;
  logic [3:0]     cnt,   next_cnt;
  logic           dir,   next_dir;
  lfld_stat_t     stat,  next_stat;
  logic [2:0]     prio,  next_prio;
  logic           req,   next_req;
  logic           low_en, next_low_en;
  logic           low_en_d;
  logic           ack,   next_ack;
  logic [31:0]    rdata, next_rdata;
  logic           tx_q,  next_tx;
  logic           cint,  next_cint;
  logic           lint,  next_lint;
  logic [7:0]     mem      [BUF_DEPTH];
  logic [7:0]     next_mem [BUF_DEPTH];
  logic           wr_go, start, abort, tick, busy, low_evt, done_set, err_set;
  logic [7:0]     wd;
  logic [2:0]     clr;
  logic           u_tx;
  lfld_byte_res_t u_res;

  lfld_serdes #(
    .BIT_CYC (BIT_CYC)
  ) u_serdes (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .en_i      ((state == ST_TX_BYTE) || (state == ST_RX_BYTE)),
    .tx_mode_i (state == ST_TX_BYTE),
    .tx_byte_i (mem[idx]),
    .rx_pin_i  (pin_s),
    .tx_o      (u_tx),
    .res_o     (u_res)
  );

  // ------------------------------------------------------------------
  // bus slave, register writes, frame sequencer, flags
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;  next_cyc  = cyc;   next_bits = bits;  next_idx  = idx;
    next_brk   = brk;    next_cnt  = cnt;   next_dir  = dir;   next_prio = prio;
    next_req   = req;    next_low_en = low_en; next_mem = mem;  next_rdata = rdata;
    busy       = (state != ST_IDLE);
    // one wait state: request sampled, answered at the next edge
    next_ack   = (avs_read_i || avs_write_i) && !ack;
    wr_go      = avs_write_i && ack && avs_byteenable_i[0];
    wd         = avs_writedata_i[7:0];
    start      = 1'b0;
    abort      = 1'b0;
    clr        = 3'h0;
    done_set   = 1'b0;
    err_set    = 1'b0;
    tick       = (cyc == CYC_LAST);
    if (avs_read_i && !ack) begin
      unique case (avs_address_i)
        OFS_MODE: next_rdata = {31'h0, low_en};
        OFS_BRK:  next_rdata = {26'h0, brk};
        OFS_RFC:  next_rdata = {24'h0, busy, 2'h0, dir, cnt};
        OFS_STAT: next_rdata = {29'h0, stat};
        OFS_LDIC: next_rdata = {28'h0, req, prio};
        default:  next_rdata = (avs_address_i[7:6] == OFS_DATA_HI) ?
                               {24'h0, mem[avs_address_i[5:2]]} : 32'h0;
      endcase
    end
    if (wr_go) begin
      unique case (avs_address_i)
        OFS_MODE: next_low_en = wd[0];
        OFS_BRK:  if (!busy) next_brk = wd[5:0];  // frame settings frozen while busy
        OFS_RFC: begin
          if (!busy) begin
            next_cnt = wd[3:0];
            next_dir = wd[RFC_DIR_BIT];
            start    = wd[RFC_GO_BIT];
          end
          abort = wd[RFC_ABORT_BIT] && busy;
        end
        OFS_STAT: clr = ~wd[2:0];  // only zeros clear // see R01
        OFS_LDIC: begin
          next_prio = wd[2:0];
          next_req  = wd[LDIC_REQ_BIT];
        end
        default: if (avs_address_i[7:6] == OFS_DATA_HI) next_mem[avs_address_i[5:2]] = wd;
      endcase
    end
    // bit-time pacing for break, delimiter and space
    if ((state == ST_BRK_LOW) || (state == ST_BRK_DLM) || (state == ST_TX_SPACE)) begin
      next_cyc = tick ? '0 : cyc + CW'(1);
      if (tick && (bits != 5'h0)) next_bits = bits - 5'h1;
    end
    unique case (state)
      ST_IDLE: if (start) begin
        next_state = ST_BRK_LOW;
        next_cyc   = '0;
        next_idx   = 4'h0;
        next_bits  = 5'(BRK_LOW_BASE - 1) + {1'b0, next_brk.low};  // see R03
      end
      ST_BRK_LOW: if (tick && (bits == 5'h0)) begin
        next_state = ST_BRK_DLM;
        next_bits  = 5'(BRK_DLM_BASE - 1) + {3'h0, brk.dlm};  // see R04
      end
      ST_BRK_DLM: if (tick && (bits == 5'h0)) begin
        if (cnt == 4'h0) begin
          next_state = ST_IDLE;
          done_set   = 1'b1;
        end else begin
          next_state = dir ? ST_TX_BYTE : ST_RX_BYTE;
        end
      end
      ST_TX_BYTE: if (u_res.done) begin
        if (u_res.err) begin
          next_state = ST_IDLE;  // see R05
          err_set    = 1'b1;
        end else begin
          next_state = ST_TX_SPACE;
          next_cyc   = '0;
          next_bits  = 5'(SPACE_BITS - 1);
        end
      end
      ST_TX_SPACE: if (tick && (bits == 5'h0)) begin
        next_idx = idx + 4'h1;
        if (idx + 4'h1 == cnt) begin
          next_state = ST_IDLE;  // see R05
          done_set   = 1'b1;
        end else begin
          next_state = ST_TX_BYTE;
        end
      end
      ST_RX_BYTE: if (u_res.done) begin
        if (u_res.err) begin
          next_state = ST_IDLE;  // abort, byte dropped // see R06
          err_set    = 1'b1;
        end else begin
          next_mem[idx] = u_res.data;
          next_idx      = idx + 4'h1;
          if (idx + 4'h1 == cnt) begin
            next_state = ST_IDLE;
            done_set   = 1'b1;
          end
        end
      end
    endcase
    if (abort) begin
      next_state = ST_IDLE;
      err_set    = 1'b1;
    end
    // enable while low counts as an event as well as a falling edge
    low_evt   = low_en && ((pin_d && !pin_s) || (!low_en_d && !pin_s));  // see R07
    // set wins over a clear in the same cycle
    next_stat = (stat & lfld_stat_t'(~clr)) | {low_evt, err_set, done_set};  // see R01
    if (low_evt && !stat.low_det) next_req = 1'b1;  // see R02
    // priority 000 parks the request line // see R09
    next_lint = low_evt && !stat.low_det && (prio != 3'h0);  // see R02
    next_cint = (done_set || err_set) && !stat.done && !stat.err;  // see R08
    next_tx   = (state == ST_BRK_LOW) ? 1'b0 : ((state == ST_TX_BYTE) ? u_tx : 1'b1);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;  cyc  <= '0;       bits  <= 5'h0;  idx  <= 4'h0;
      brk   <= RST_BRK;  cnt  <= RST_CNT;  dir   <= 1'b0;  stat <= '0;
      prio  <= RST_PRIO; req  <= 1'b0;     low_en <= 1'b0; low_en_d <= 1'b0;
      ack   <= 1'b0;     rdata <= 32'h0;   tx_q  <= 1'b1;  cint <= 1'b0;
      lint  <= 1'b0;
      for (int i = 0; i < BUF_DEPTH; i++) mem[i] <= 8'h00;
    end else begin
      state <= next_state; cyc  <= next_cyc; bits  <= next_bits; idx  <= next_idx;
      brk   <= next_brk;   cnt  <= next_cnt; dir   <= next_dir;  stat <= next_stat;
      prio  <= next_prio;  req  <= next_req; low_en <= next_low_en; low_en_d <= low_en;
      ack   <= next_ack;   rdata <= next_rdata; tx_q <= next_tx; cint <= next_cint;
      lint  <= next_lint;
      mem   <= next_mem;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
  assign avs_readdata_o    = rdata;
  assign bus_tx_o          = tx_q;
  assign chan_int_o        = cint;
  assign low_int_o         = lint;

  // ------------------------------------------------------------------
  // checks; st_cyc counts cycles spent in the current state
  // ------------------------------------------------------------------
  logic [15:0] st_cyc;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || (next_state != state)) st_cyc <= 16'h0;
    else st_cyc <= st_cyc + 16'h1;
  end
  logic wr_stat;
  assign wr_stat = wr_go && (avs_address_i == OFS_STAT);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fall;
    low_en && pin_d && !pin_s;
  endsequence
  sequence s_tx_fail;
    (state == ST_TX_BYTE) && u_res.done && u_res.err;
  endsequence
  sequence s_rx_fail;
    (state == ST_RX_BYTE) && u_res.done && u_res.err;
  endsequence

  chk_err_no_selfclr: assert property ($fell(stat.err) |-> $past(wr_stat && !wd[1])) // see R01
    else $error("error flag cleared without a zero write");
  chk_done_keep_one: assert property (stat.done && wr_stat && wd[0] |=> stat.done) // see R01
    else $error("writing one changed the done flag");
  chk_low_no_reint: assert property (stat.low_det |=> !low_int_o) // see R02
    else $error("low request while low flag already set");
  chk_brk_low_len: assert property ((state == ST_BRK_LOW) && (next_state == ST_BRK_DLM) // see R03
    |-> (st_cyc == 16'((BRK_LOW_BASE + brk.low) * BIT_CYC - 1)) && !bus_tx_o)
    else $error("break low length wrong");
  chk_brk_dlm_len: assert property ((state == ST_BRK_DLM) && (next_state != ST_BRK_DLM) // see R04
    |-> (st_cyc == 16'((BRK_DLM_BASE + brk.dlm) * BIT_CYC - 1)) && bus_tx_o)
    else $error("break delimiter length wrong");
  chk_tx_abort: assert property (s_tx_fail |=> (state == ST_IDLE) && stat.err) // see R05
    else $error("transmit error did not abort");
  chk_space_len: assert property ((state == ST_TX_SPACE) && (next_state != ST_TX_SPACE) // see R05
    |-> st_cyc == 16'(SPACE_BITS * BIT_CYC - 1))
    else $error("interbyte space length wrong");
  chk_rx_abort: assert property (s_rx_fail |=> (state == ST_IDLE) && stat.err // see R06
    && $stable(idx) && $stable(mem[idx]))
    else $error("receive error did not abort");
  chk_low_edge: assert property (s_fall |=> stat.low_det) // see R07
    else $error("falling edge missed by low detect");
  chk_low_enable: assert property ($rose(low_en) && !pin_s |=> stat.low_det) // see R07
    else $error("enable while low missed");
  chk_chan_merge: assert property ((stat.done || stat.err) |=> !chan_int_o) // see R08
    else $error("new channel request while source flag set");
endmodule // lfld_channel

// ==== verif/lfld_node.sv ====
// lfld_node: remote lin node plus transceiver on a wired-and bus
// assumes sys_clk_i is the channel clock and go_i is a one-cycle strobe
`timescale 1ns/10ps
module lfld_node #(
  parameter int BIT_CYC = 16
) (
  // clock
  input  wire logic       sys_clk_i,
  // stimulus from the bench
  input  wire logic       go_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       low_i,
  // bus
  input  wire logic       dev_tx_i,
  output logic            wire_o,
  output logic            busy_o
);
  logic [9:0] shift;
  int         bits;
  int         cyc;
  // ----------------------------------------------------------------
  // 8n1 sender, lsb first; a released line goes back to the pull-up
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (go_i && bits == 0) begin
      shift <= {1'b1, byte_i, 1'b0};
      bits  <= 10;
      cyc   <= 0;
    end else if (bits != 0) begin
      cyc <= (cyc == BIT_CYC - 1) ? 0 : cyc + 1;
      if (cyc == BIT_CYC - 1) begin
        shift <= {1'b1, shift[9:1]};
        bits  <= bits - 1;
      end
    end
  end
  // dominant low wins, so a low from the node or low_i overrides the device's own high level
  assign busy_o = (bits != 0);
  assign wire_o = dev_tx_i & !low_i & (bits == 0 || shift[0]);
endmodule // lfld_node

// ==== verif/test_lin_frame_and_low_detect.sv ====
// test_lin_frame_and_low_detect: self-checking bench of the lin channel
// assumes lfld_node as far side and a bit time shortened to 16 cycles
`timescale 1ns/10ps
module test_lin_frame_and_low_detect;
  import lfld_pkg::*;
  localparam int B = 16;
  logic        sys_clk, rst, rd, wr, wreq, tx, c_int, l_int, pin, nd_go, nd_low, nd_busy;
  logic        ds, dp;
  logic [7:0]  addr, nd_byte, dv, b0, b1;
  logic [31:0] wd, rdata;
  logic [3:0]  be;
  logic [32:0] e;
  logic [32:0] rd_q[$];
  logic [7:0]  by_q[$];
  int          brk_q[$];
  int          err_total, checks, seed, cyc, n_cint, n_lint, mon_on, run, hi_arm;
  logic        prev;

  lfld_channel #(.BIT_CYC(B)) dut (.sys_clk_i(sys_clk), .rst_i(rst), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .bus_input_pin_i(pin),
    .bus_tx_o(tx), .chan_int_o(c_int), .low_int_o(l_int));
  lfld_node #(.BIT_CYC(B)) node (.sys_clk_i(sys_clk), .go_i(nd_go), .byte_i(nd_byte),
    .low_i(nd_low), .dev_tx_i(tx), .wire_o(pin), .busy_o(nd_busy));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // request held until waitrequest is sampled low, released after
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    addr <= a;
    rd   <= !w;
    wr   <= w;
    wd   <= d;
    @(posedge sys_clk);
    while (wreq !== 1'b0) @(posedge sys_clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr_(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    rd_q.push_back({1'b1, x});
    bus(1'b0, a, 32'h0, q);
  endtask
  // poll the busy bit; these reads carry no expectation
  task automatic idle();
    logic [31:0] q;
    q = 32'h80;
    while (q[7] !== 1'b0) begin
      rd_q.push_back(33'h0);
      bus(1'b0, OFS_RFC, 32'h0, q);
    end
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge sys_clk);
    nd_byte <= b;
    nd_go   <= 1'b1;
    @(posedge sys_clk);
    nd_go <= 1'b0;
    @(posedge sys_clk);
    while (nd_busy) @(posedge sys_clk);
  endtask
  task automatic lowp();
    @(posedge sys_clk);
    nd_low <= 1'b1;
    repeat (6) @(posedge sys_clk);
    nd_low <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  // load break fields and buffer, then start a frame
  task automatic frame(input logic [3:0] lo, input logic [1:0] dl, input logic [3:0] n,
                       input logic dir);
    logic [7:0] b;
    wr_(OFS_BRK, {26'h0, dl, lo});
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      wr_(8'h40 + 8'(4 * i), {24'h0, b});
      if (dir && mon_on) by_q.push_back(b);
    end
    if (dir && mon_on) begin
      brk_q.push_back((13 + lo) * B);
      brk_q.push_back((1 + dl) * B);
    end
    wr_(OFS_RFC, {26'h0, 1'b1, dir, n});
  endtask

  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  // read answers against the oldest noted expectation
  always @(posedge sys_clk) begin
    if (rd && wreq === 1'b0) begin
      e = rd_q.pop_front();
      if (e[32]) chk(rdata, e[31:0], "read");
    end
    n_cint += (c_int === 1'b1);
    n_lint += (l_int === 1'b1);
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end
  // low and high run lengths of the break
  always @(posedge sys_clk) begin
    if (tx !== prev) begin
      if (prev === 1'b0 && run >= 13 * B && brk_q.size() != 0) begin
        chk(run, brk_q.pop_front(), "break low");
        hi_arm <= 1;
      end else if (prev === 1'b1 && hi_arm != 0) begin
        chk(run, brk_q.pop_front(), "delimiter");
        hi_arm <= 0;
      end
      run <= 1;
    end else run <= run + 1;
    prev <= tx;
  end
  // 8n1 decoder on the transmit line; framing failures (the break) are skipped
  initial forever begin
    @(posedge sys_clk);
    if (tx === 1'b0 && mon_on != 0) begin
      repeat (B / 2 - 1) @(posedge sys_clk);
      ds = tx;
      for (int k = 0; k < 8; k++) begin
        repeat (B) @(posedge sys_clk);
        dv[k] = tx;
      end
      repeat (B) @(posedge sys_clk);
      dp = tx;
      if (ds === 1'b0 && dp === 1'b1)
        chk({24'h0, dv}, by_q.size() ? {24'h0, by_q.pop_front()} : 32'h1ff, "byte");
      while (tx !== 1'b1) @(posedge sys_clk);
    end
  end

  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    seed = 13896;
    {rst, rd, wr, addr, wd, be, nd_go, nd_byte, nd_low} = {1'b1, 42'h0, 4'h1, 10'h0};
    mon_on = 1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values, unmapped places and a write without byte lane 0
    for (int i = 0; i < 6; i++) rd_(8'(4 * i), 32'h0);
    rd_(8'h40, 32'h0);
    rd_(8'h80, 32'h0);
    be <= 4'h0;
    wr_(OFS_MODE, 32'h1);
    be <= 4'h1;
    rd_(OFS_MODE, 32'h0);
    // transmit frames: longest break, then the full byte count
    frame(4'hf, 2'h3, 4'h1, 1'b1);
    idle();
    frame(4'($random(seed)), 2'($random(seed)), 4'hf, 1'b1);
    idle();
    // readback fault while done still stands: error, no new request
    mon_on = 0;
    frame(4'h0, 2'h0, 4'h2, 1'b1);
    @(posedge tx);
    nd_low <= 1'b1;
    repeat (12 * B) @(posedge sys_clk);
    nd_low <= 1'b0;
    idle();
    mon_on = 1;
    repeat (4) @(posedge sys_clk);
    chk(n_cint, 1, "chan int");
    rd_(OFS_STAT, 32'h3);
    wr_(OFS_STAT, 32'h7);
    rd_(OFS_STAT, 32'h3);
    wr_(OFS_STAT, 32'h0);
    rd_(OFS_STAT, 32'h0);
    // receive two bytes sent by the node
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    frame(4'h0, 2'h0, 4'h2, 1'b0);
    @(posedge tx);
    repeat (2 * B) @(posedge sys_clk);
    send(b0);
    send(b1);
    idle();
    rd_(OFS_STAT, 32'h1);
    rd_(8'h40, {24'h0, b0});
    rd_(8'h44, {24'h0, b1});
    // receive aborted after one of three bytes
    wr_(OFS_STAT, 32'h0);
    frame(4'h0, 2'h0, 4'h3, 1'b0);
    @(posedge tx);
    repeat (2 * B) @(posedge sys_clk);
    send(b1);
    wr_(OFS_RFC, 32'h40);
    idle();
    rd_(OFS_STAT, 32'h2);
    rd_(8'h40, {24'h0, b1});
    repeat (4) @(posedge sys_clk);
    chk(n_cint, 3, "chan int");
    // receive framing fault: the node holds the stop bit low
    wr_(OFS_STAT, 32'h0);
    frame(4'h0, 2'h0, 4'h2, 1'b0);
    @(posedge tx);
    repeat (2 * B) @(posedge sys_clk);
    nd_low <= 1'b1;
    repeat (12 * B) @(posedge sys_clk);
    nd_low <= 1'b0;
    idle();
    rd_(OFS_STAT, 32'h2);
    chk(n_cint, 4, "chan int");
    // low detect on a falling edge, then again while the flag stands
    wr_(OFS_STAT, 32'h0);
    wr_(OFS_LDIC, 32'h5);
    wr_(OFS_MODE, 32'h1);
    lowp();
    chk(n_lint, 1, "low int");
    rd_(OFS_STAT, 32'h4);
    rd_(OFS_LDIC, 32'hd);
    lowp();
    chk(n_lint, 1, "low int");
    // enabling detection while the pin is already low
    wr_(OFS_STAT, 32'h0);
    wr_(OFS_LDIC, 32'h5);
    wr_(OFS_MODE, 32'h0);
    nd_low <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd_(OFS_STAT, 32'h0);
    wr_(OFS_MODE, 32'h1);
    repeat (8) @(posedge sys_clk);
    nd_low <= 1'b0;
    chk(n_lint, 2, "low int");
    rd_(OFS_STAT, 32'h4);
    // wait-mode preparation: request parked at priority zero, flag cleared
    wr_(OFS_LDIC, 32'h0);
    wr_(OFS_STAT, 32'h0);
    lowp();
    chk(n_lint, 2, "low int");
    rd_(OFS_STAT, 32'h4);
    rd_(OFS_LDIC, 32'h8);
    repeat (4) @(posedge sys_clk);
    wrap_up();
  end
endmodule // test_lin_frame_and_low_detect
